// [design/qtx_consts.svh]
`ifndef QTX_CONSTS_SVH
`define QTX_CONSTS_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define QTX_CTRL_OFS 9'h170
`define QTX_STAT_OFS 9'h172
`define QTX_CTRL_RST 16'h0000
`define QTX_CTRL_MASK 16'h01fd
`define QTX_STAT_RST 16'h0000

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define QTX_BIT_ICMP 8
`define QTX_BIT_UDP 7
`define QTX_BIT_TCP 6
`define QTX_BIT_FLUSH 5
`define QTX_BIT_FC 4
`define QTX_BIT_PAD 3
`define QTX_BIT_CRC 2
`define QTX_BIT_TXE 0
`define QTX_BIT_LC 13
`define QTX_BIT_MC 12
`define QTX_ID_W 6

// ---------------------------------------------------------------
// Frame layout and counts
// ---------------------------------------------------------------
`define QTX_MIN_DATA 60
`define QTX_CRC_BYTES 4
`define QTX_MIN_FRAME 64
`define QTX_OFS_TYPE_HI 12
`define QTX_OFS_TYPE_LO 13
`define QTX_OFS_IHL 14
`define QTX_OFS_LEN_HI 16
`define QTX_OFS_LEN_LO 17
`define QTX_OFS_FRAG_HI 20
`define QTX_OFS_FRAG_LO 21
`define QTX_OFS_PROTO 23
`define QTX_OFS_ADDR_FIRST 26
`define QTX_OFS_ADDR_LAST 33
`define QTX_CSUM_OFS_ICMP 2
`define QTX_CSUM_OFS_UDP 6
`define QTX_CSUM_OFS_TCP 16
`define QTX_ETH_IPV4 16'h0800
`define QTX_PROTO_ICMP 8'h01
`define QTX_PROTO_TCP 8'h06
`define QTX_PROTO_UDP 8'h11
`define QTX_PAUSE_TYPE 16'h8808
`define QTX_PAUSE_OPCODE 16'h0001
`define QTX_PAUSE_DA 48'h0180c2000001
`define QTX_PAUSE_TIME 16'hffff
`define QTX_CRC_INIT 32'hffffffff
`define QTX_CRC_POLY 32'hedb88320

`endif

// [design/qtx_pkg.sv]
package qtx_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD = 3'b001,
		ST_SEND = 3'b010,
		ST_PAD = 3'b011,
		ST_CRC = 3'b100,
		ST_PAUSE = 3'b101
	} tx_state_type;

	typedef enum logic [1:0] {
		PR_NONE = 2'b00,
		PR_ICMP = 2'b01,
		PR_UDP = 2'b10,
		PR_TCP = 2'b11
	} proto_type;

endpackage : qtx_pkg

// [design/tx_fifo.sv]
`timescale 1ns/1ps

module tx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic i_clock, // System clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_flush, // Empty the queue
	input wire logic i_in_valid, // Write side valid
	output logic o_in_ready, // Write side ready
	input wire logic [WIDTH-1:0] i_in_data, // Write data
	output logic o_out_valid, // Read side valid
	input wire logic i_out_ready, // Read side ready
	output logic [WIDTH-1:0] o_out_data // Read data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
		(wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	// Refuse writes during flush so nothing survives it
	assign o_in_ready = ~full & ~i_flush;
	assign o_out_valid = ~empty & ~i_flush;
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else if (i_flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end

endmodule : tx_fifo

// [design/queue_tx_control_status.sv]
`timescale 1ns/1ps
`include "qtx_consts.svh"

module queue_tx_control_status #(
	parameter int FIFO_DEPTH = 32,
	parameter int MAX_FRAME = 2048,
	parameter int LEVEL_W = 12,
	parameter logic [LEVEL_W-1:0] RX_THRESH = 12'h800
) (
	input wire logic i_clock, // 40 MHz system clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic [8:0] i_addr, // Register byte address
	input wire logic [15:0] i_wdata, // Register write data
	input wire logic i_wr, // Register write strobe
	input wire logic i_rd, // Register read strobe
	output logic [15:0] o_rdata, // Read data, cycle after i_rd
	input wire logic i_in_valid, // Host frame byte valid
	output logic o_in_ready, // Host frame byte accepted
	input wire logic [7:0] i_in_data, // Host frame byte
	input wire logic i_in_last, // Last byte of host frame
	output logic o_tx_valid, // MAC byte valid
	input wire logic i_tx_ready, // MAC takes byte
	output logic [7:0] o_tx_data, // MAC byte
	output logic o_tx_last, // Last byte of frame on wire
	input wire logic i_tx_done, // MAC finished a frame
	input wire logic i_late_col, // Late collision, with done
	input wire logic i_max_col, // Collision limit, with done
	input wire logic i_full_duplex, // Link is full duplex
	input wire logic [LEVEL_W-1:0] i_rx_level, // Receive buffer fill
	input wire logic [47:0] i_station_addr, // Source address for PAUSE
	output logic o_backpressure, // Half duplex jam request
	output logic o_tx_running // Module in running state
);

	localparam int AW = $clog2(MAX_FRAME);
	localparam int LW = AW + 1;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [15:0] ctrl_r;
	logic [15:0] stat_r;
	logic [15:0] rdata_r;
	logic tx_module_enable;
	logic flush;
	logic fc_en;

	assign tx_module_enable = ctrl_r[`QTX_BIT_TXE];
	assign flush = ctrl_r[`QTX_BIT_FLUSH];
	assign fc_en = ctrl_r[`QTX_BIT_FC];

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_r <= `QTX_CTRL_RST;
		end else if (i_wr && i_addr == `QTX_CTRL_OFS) begin
			ctrl_r <= i_wdata & `QTX_CTRL_MASK;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r <= '0;
		end else if (i_rd) begin
			case (i_addr)
				`QTX_CTRL_OFS: rdata_r <= ctrl_r;
				`QTX_STAT_OFS: rdata_r <= stat_r;
				default: rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end
	assign o_rdata = rdata_r;

	ctrl_rdback_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		i_wr && i_addr == `QTX_CTRL_OFS ##1 i_rd && i_addr == `QTX_CTRL_OFS
		|=> o_rdata == ($past(i_wdata, 2) & `QTX_CTRL_MASK))
		else $error("control readback mismatch");

	// ---------------------------------------------------------------
	// Queue
	// ---------------------------------------------------------------
	logic q_valid;
	logic q_pop;
	logic [8:0] q_data;

	tx_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_flush(flush),
		.i_in_valid(i_in_valid),
		.o_in_ready(o_in_ready),
		.i_in_data({i_in_last, i_in_data}),
		.o_out_valid(q_valid),
		.i_out_ready(q_pop),
		.o_out_data(q_data)
	);

	// Ready is judged in the flush cycle; the bit may clear on the next one
	flush_empty_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		flush |-> !o_in_ready ##1 !q_valid)
		else $error("queue not empty during flush");

	// ---------------------------------------------------------------
	// Flow control
	// ---------------------------------------------------------------
	logic over_thresh;
	logic pause_pend_r;
	logic pause_armed_r;
	logic bp_r;
	logic pause_start;

	assign over_thresh = (i_rx_level >= RX_THRESH);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pause_pend_r <= 1'b0;
			pause_armed_r <= 1'b1;
		end else begin
			// New crossing beats the consume of the old request
			if (fc_en && i_full_duplex && over_thresh && pause_armed_r) begin
				pause_pend_r <= 1'b1;
				pause_armed_r <= 1'b0;
			end else if (pause_start || !fc_en || !i_full_duplex) begin
				pause_pend_r <= 1'b0;
			end
			if (!over_thresh) begin
				pause_armed_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bp_r <= 1'b0;
		end else begin
			bp_r <= fc_en && !i_full_duplex && over_thresh;
		end
	end
	assign o_backpressure = bp_r;

	fc_off_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		!fc_en |=> !o_backpressure && !pause_pend_r)
		else $error("flow control active while disabled");

	// ---------------------------------------------------------------
	// Frame engine
	// ---------------------------------------------------------------
	qtx_pkg::tx_state_type state_r;
	qtx_pkg::tx_state_type state_nxt;
	qtx_pkg::proto_type proto_r;
	logic [7:0] mem_r [MAX_FRAME];
	logic [LW-1:0] idx_r;
	logic [LW-1:0] len_r;
	logic [1:0] crc_cnt_r;
	logic [31:0] crc_r;
	logic [`QTX_ID_W-1:0] id_cnt_r;
	logic [`QTX_ID_W-1:0] cur_id_r;
	logic is_pause_r;
	logic frm_pad_r;
	logic frm_crc_r;
	logic emit_en;
	logic emit_final;
	logic [7:0] emit_byte;
	logic advance;
	logic out_valid_r;
	logic [7:0] out_data_r;
	logic out_last_r;

	function automatic logic [31:0] crc_byte(input logic [31:0] c,
		input logic [7:0] b);
		logic [31:0] x;
		x = c ^ {24'h000000, b};
		for (int k = 0; k < 8; k++) begin
			x = x[0] ? ((x >> 1) ^ `QTX_CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc_byte

	function automatic logic [7:0] pause_byte(input logic [LW-1:0] i,
		input logic [47:0] sa);
		logic [143:0] hdr;
		hdr = {`QTX_PAUSE_DA, sa, `QTX_PAUSE_TYPE, `QTX_PAUSE_OPCODE,
			`QTX_PAUSE_TIME};
		if (i < LW'(18)) begin
			return hdr[143 - 8 * i -: 8];
		end
		return 8'h00;
	endfunction : pause_byte

	// Checksum parse state, filled while the frame loads
	logic [7:0] ld_byte;
	logic ld_last;
	logic [7:0] type_hi_r;
	logic is_ip_r;
	logic frag_r;
	logic [LW-1:0] l4_start_r;
	logic [LW-1:0] ip_end_r;
	logic [15:0] ip_len_r;
	logic [LW-1:0] hdr_len_r;
	logic [31:0] sum_r;
	logic [31:0] psum_r;
	logic [LW-1:0] csum_pos;
	logic [15:0] word;
	logic in_l4;
	logic [31:0] total;
	logic [16:0] fold1;
	logic [15:0] fold2;
	logic [15:0] csum_val;
	logic csum_do_r;
	logic csum_want;

	assign ld_byte = q_data[7:0];
	assign ld_last = q_data[8];
	assign word = idx_r[0] ? {8'h00, ld_byte} : {ld_byte, 8'h00};

	always_comb begin
		case (proto_r)
			qtx_pkg::PR_ICMP: csum_pos = l4_start_r + LW'(`QTX_CSUM_OFS_ICMP);
			qtx_pkg::PR_UDP: csum_pos = l4_start_r + LW'(`QTX_CSUM_OFS_UDP);
			qtx_pkg::PR_TCP: csum_pos = l4_start_r + LW'(`QTX_CSUM_OFS_TCP);
			default: csum_pos = '1;
		endcase
	end

	// Checksum field itself counts as zero in the sum
	assign in_l4 = is_ip_r && idx_r >= l4_start_r && idx_r < ip_end_r &&
		idx_r != csum_pos && idx_r != csum_pos + 1'b1;

	assign total = sum_r + ((proto_r == qtx_pkg::PR_UDP ||
		proto_r == qtx_pkg::PR_TCP) ? psum_r + 32'(ip_len_r) -
		32'(hdr_len_r) + ((proto_r == qtx_pkg::PR_UDP) ?
		32'(`QTX_PROTO_UDP) : 32'(`QTX_PROTO_TCP)) : 32'h00000000);
	assign fold1 = {1'b0, total[15:0]} + {1'b0, total[31:16]};
	assign fold2 = fold1[15:0] + {15'h0000, fold1[16]};
	assign csum_val = (~fold2 == 16'h0000 && proto_r == qtx_pkg::PR_UDP) ?
		16'hffff : ~fold2;

	always_comb begin
		case (proto_r)
			qtx_pkg::PR_ICMP: csum_want = ctrl_r[`QTX_BIT_ICMP];
			qtx_pkg::PR_UDP: csum_want = ctrl_r[`QTX_BIT_UDP];
			qtx_pkg::PR_TCP: csum_want = ctrl_r[`QTX_BIT_TCP];
			default: csum_want = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			type_hi_r <= '0;
			is_ip_r <= 1'b0;
			frag_r <= 1'b0;
			proto_r <= qtx_pkg::PR_NONE;
			l4_start_r <= '1;
			ip_end_r <= '0;
			ip_len_r <= '0;
			hdr_len_r <= '0;
			sum_r <= '0;
			psum_r <= '0;
		end else if (state_r == qtx_pkg::ST_IDLE) begin
			is_ip_r <= 1'b0;
			frag_r <= 1'b0;
			proto_r <= qtx_pkg::PR_NONE;
			l4_start_r <= '1;
			ip_end_r <= '0;
			sum_r <= '0;
			psum_r <= '0;
		end else if (state_r == qtx_pkg::ST_LOAD && q_pop) begin
			case (idx_r)
				LW'(`QTX_OFS_TYPE_HI): type_hi_r <= ld_byte;
				LW'(`QTX_OFS_TYPE_LO):
					is_ip_r <= ({type_hi_r, ld_byte} == `QTX_ETH_IPV4);
				LW'(`QTX_OFS_IHL): begin
					hdr_len_r <= LW'({ld_byte[3:0], 2'b00});
					l4_start_r <= LW'(`QTX_OFS_IHL) + LW'({ld_byte[3:0], 2'b00});
				end
				LW'(`QTX_OFS_LEN_HI): ip_len_r[15:8] <= ld_byte;
				LW'(`QTX_OFS_LEN_LO): begin
					ip_len_r[7:0] <= ld_byte;
					ip_end_r <= LW'(`QTX_OFS_IHL) + LW'({ip_len_r[15:8], ld_byte});
				end
				LW'(`QTX_OFS_FRAG_HI): frag_r <= ld_byte[5] | (|ld_byte[4:0]);
				LW'(`QTX_OFS_FRAG_LO): frag_r <= frag_r | (|ld_byte);
				LW'(`QTX_OFS_PROTO): begin
					case (ld_byte)
						`QTX_PROTO_ICMP: proto_r <= qtx_pkg::PR_ICMP;
						`QTX_PROTO_UDP: proto_r <= qtx_pkg::PR_UDP;
						`QTX_PROTO_TCP: proto_r <= qtx_pkg::PR_TCP;
						default: proto_r <= qtx_pkg::PR_NONE;
					endcase
				end
				default: begin
				end
			endcase
			if (idx_r >= LW'(`QTX_OFS_ADDR_FIRST) &&
				idx_r <= LW'(`QTX_OFS_ADDR_LAST)) begin
				psum_r <= psum_r + 32'(word);
			end
			if (in_l4) begin
				sum_r <= sum_r + 32'(word);
			end
		end
	end

	// Store and forward: the checksum sits ahead of data not yet seen
	always_ff @(posedge i_clock) begin
		if (state_r == qtx_pkg::ST_LOAD && q_pop && idx_r < LW'(MAX_FRAME)) begin
			mem_r[idx_r[AW-1:0]] <= ld_byte;
		end
	end

	assign advance = ~out_valid_r | i_tx_ready;
	assign q_pop = (state_r == qtx_pkg::ST_LOAD) & q_valid;
	assign pause_start = (state_r == qtx_pkg::ST_IDLE) &&
		(state_nxt == qtx_pkg::ST_PAUSE);

	always_comb begin
		state_nxt = state_r;
		emit_en = 1'b0;
		emit_final = 1'b0;
		emit_byte = 8'h00;
		case (state_r)
			qtx_pkg::ST_IDLE: begin
				// Stopped state: nothing new starts without enable
				if (tx_module_enable && !flush) begin
					if (pause_pend_r) begin
						state_nxt = qtx_pkg::ST_PAUSE;
					end else if (q_valid) begin
						state_nxt = qtx_pkg::ST_LOAD;
					end
				end
			end
			qtx_pkg::ST_LOAD: begin
				if (flush) begin
					state_nxt = qtx_pkg::ST_IDLE;
				end else if (q_pop && ld_last) begin
					state_nxt = qtx_pkg::ST_SEND;
				end
			end
			qtx_pkg::ST_SEND: begin
				emit_en = advance;
				if (csum_do_r && idx_r == csum_pos) begin
					emit_byte = csum_val[15:8];
				end else if (csum_do_r && idx_r == csum_pos + 1'b1) begin
					emit_byte = csum_val[7:0];
				end else begin
					emit_byte = mem_r[idx_r[AW-1:0]];
				end
				if (idx_r + 1'b1 >= len_r) begin
					if (frm_pad_r && len_r < LW'(`QTX_MIN_DATA)) begin
						state_nxt = advance ? qtx_pkg::ST_PAD : state_r;
					end else if (frm_crc_r) begin
						state_nxt = advance ? qtx_pkg::ST_CRC : state_r;
					end else begin
						emit_final = 1'b1;
						state_nxt = advance ? qtx_pkg::ST_IDLE : state_r;
					end
				end
			end
			qtx_pkg::ST_PAD, qtx_pkg::ST_PAUSE: begin
				emit_en = advance;
				emit_byte = (state_r == qtx_pkg::ST_PAUSE) ?
					pause_byte(idx_r, i_station_addr) : 8'h00;
				if (idx_r + 1'b1 >= LW'(`QTX_MIN_DATA)) begin
					if (frm_crc_r || state_r == qtx_pkg::ST_PAUSE) begin
						state_nxt = advance ? qtx_pkg::ST_CRC : state_r;
					end else begin
						emit_final = 1'b1;
						state_nxt = advance ? qtx_pkg::ST_IDLE : state_r;
					end
				end
			end
			qtx_pkg::ST_CRC: begin
				emit_en = advance;
				emit_byte = ~crc_r[8 * crc_cnt_r +: 8];
				if (crc_cnt_r == 2'd3) begin
					emit_final = 1'b1;
					state_nxt = advance ? qtx_pkg::ST_IDLE : state_r;
				end
			end
			default: state_nxt = qtx_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= qtx_pkg::ST_IDLE;
			idx_r <= '0;
			len_r <= '0;
			crc_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r) begin
				idx_r <= '0;
				crc_cnt_r <= '0;
			end else if (q_pop || (emit_en && state_r != qtx_pkg::ST_CRC)) begin
				idx_r <= idx_r + 1'b1;
			end else if (emit_en) begin
				crc_cnt_r <= crc_cnt_r + 1'b1;
			end
			if (state_r == qtx_pkg::ST_LOAD && q_pop && idx_r < LW'(MAX_FRAME)) begin
				len_r <= idx_r + 1'b1;
			end
			// Pad counts on from the stored length; PAUSE starts from zero
			if (state_r == qtx_pkg::ST_SEND && state_nxt == qtx_pkg::ST_PAD) begin
				idx_r <= len_r;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crc_r <= `QTX_CRC_INIT;
		end else if (state_r == qtx_pkg::ST_IDLE) begin
			crc_r <= `QTX_CRC_INIT;
		end else if (emit_en && state_r != qtx_pkg::ST_CRC) begin
			crc_r <= crc_byte(crc_r, emit_byte);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			csum_do_r <= 1'b0;
			frm_pad_r <= 1'b0;
			frm_crc_r <= 1'b0;
			is_pause_r <= 1'b0;
			id_cnt_r <= '0;
			cur_id_r <= '0;
		end else begin
			if (flush) begin
				id_cnt_r <= '0;
			end else if (state_r == qtx_pkg::ST_IDLE &&
				state_nxt == qtx_pkg::ST_LOAD) begin
				cur_id_r <= id_cnt_r;
				id_cnt_r <= id_cnt_r + 1'b1;
				is_pause_r <= 1'b0;
			end else if (pause_start) begin
				is_pause_r <= 1'b1;
				frm_crc_r <= 1'b1;
			end
			if (state_r == qtx_pkg::ST_LOAD && state_nxt == qtx_pkg::ST_SEND) begin
				csum_do_r <= is_ip_r && !frag_r && csum_want;
				frm_pad_r <= ctrl_r[`QTX_BIT_PAD];
				frm_crc_r <= ctrl_r[`QTX_BIT_CRC];
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_valid_r <= 1'b0;
			out_data_r <= '0;
			out_last_r <= 1'b0;
		end else if (advance) begin
			out_valid_r <= emit_en;
			out_data_r <= emit_byte;
			out_last_r <= emit_final;
		end
	end
	assign o_tx_valid = out_valid_r;
	assign o_tx_data = out_data_r;
	assign o_tx_last = out_last_r;
	assign o_tx_running = tx_module_enable;

	// Identity of the frame on the wire; the next one may already be loading
	logic [`QTX_ID_W-1:0] wire_id_r;
	logic wire_pause_r;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wire_id_r <= '0;
			wire_pause_r <= 1'b0;
		end else if (emit_en && emit_final) begin
			wire_id_r <= cur_id_r;
			wire_pause_r <= is_pause_r;
		end
	end

	// Helper count of bytes put on the wire in the current frame
	logic [LW:0] out_cnt_r;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_cnt_r <= '0;
		end else if (emit_en) begin
			out_cnt_r <= emit_final ? '0 : out_cnt_r + 1'b1;
		end
	end

	pad_len_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		emit_en && emit_final && frm_pad_r && frm_crc_r && !is_pause_r
		|-> out_cnt_r + 1'b1 >= (LW + 1)'(`QTX_MIN_FRAME))
		else $error("padded frame below minimum length");

	crc_four_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		state_r != qtx_pkg::ST_CRC ##1 state_r == qtx_pkg::ST_CRC
		|-> (state_r == qtx_pkg::ST_CRC)[*4])
		else $error("CRC field shorter than four bytes");

	stop_wait_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		state_r == qtx_pkg::ST_SEND && !emit_final && !tx_module_enable
		|=> state_r != qtx_pkg::ST_IDLE)
		else $error("frame cut short by disable");

	idle_stop_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		state_r == qtx_pkg::ST_IDLE && !tx_module_enable |=> state_r == qtx_pkg::ST_IDLE)
		else $error("transmit started while disabled");

	pause_fd_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		pause_start |-> fc_en && i_full_duplex)
		else $error("PAUSE without full duplex flow control");

	csum_gate_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(csum_do_r) |-> !frag_r && $past(csum_want))
		else $error("checksum inserted while not enabled");

	// ---------------------------------------------------------------
	// Status
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stat_r <= `QTX_STAT_RST;
		end else if (i_tx_done && !wire_pause_r) begin
			stat_r <= '0;
			stat_r[`QTX_BIT_LC] <= i_late_col;
			stat_r[`QTX_BIT_MC] <= i_max_col;
			stat_r[`QTX_ID_W-1:0] <= wire_id_r;
		end
	end

	status_upd_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		i_tx_done && !wire_pause_r
		|=> stat_r[`QTX_BIT_LC] == $past(i_late_col)
		&& stat_r[`QTX_BIT_MC] == $past(i_max_col)
		&& stat_r[`QTX_ID_W-1:0] == $past(wire_id_r))
		else $error("status not replaced at frame completion");

endmodule : queue_tx_control_status

// [dv/mac_model.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------
// MAC side byte sink with completion report
// ---------------------------------------------------------------
module mac_model (
	input wire logic i_clock, // System clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_valid, // Byte offered
	input wire logic i_last, // Final byte of frame
	input wire logic i_stall, // Hold ready low
	input wire logic [1:0] i_col, // Late and max flags to report
	input wire logic [7:0] i_data, // Byte on the wire
	output logic o_ready, // Byte taken
	output logic o_done, // Frame finished pulse
	output logic o_late, // Late collision, with done
	output logic o_max, // Max collision, with done
	output logic [15:0] o_bytes, // Size of last frame
	output logic [7:0] o_first // First byte of last frame
);
	logic [15:0] cnt_r;
	logic fin;
	assign o_ready = !i_stall;
	assign fin = i_valid && o_ready && i_last;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 16'h0000;
			o_bytes <= 16'h0000;
			o_first <= 8'h00;
		end else if (i_valid && o_ready) begin
			cnt_r <= fin ? 16'h0000 : cnt_r + 16'h0001;
			if (cnt_r == 16'h0000)
				o_first <= i_data;
			if (fin)
				o_bytes <= cnt_r + 16'h0001;
		end
	end
	// Flags toggle outside done so a stale value is never trusted
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_done <= 1'b0;
			o_late <= 1'b0;
			o_max <= 1'b0;
		end else begin
			o_done <= fin;
			o_late <= fin ? i_col[1] : !o_late;
			o_max <= fin ? i_col[0] : !o_max;
		end
	end
endmodule : mac_model

// [dv/queue_tx_control_status_test.sv]
`timescale 1ns/1ps

module queue_tx_control_status_test;
	logic i_clock = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [8:0] i_addr = 9'h000;
	logic [15:0] i_wdata = 16'h0000, o_rdata, bytes;
	logic i_in_valid = 1'b0, i_in_last = 1'b0, o_in_ready, o_tx_valid;
	logic [7:0] i_in_data = 8'h00, o_tx_data, first;
	logic o_tx_last, tx_ready, done, late, maxc, o_backpressure, o_tx_running;
	logic i_full_duplex = 1'b0, stall = 1'b0;
	logic [1:0] col = 2'b00;
	logic [11:0] i_rx_level = 12'h000;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	// ctrl, length, collisions, bytes on wire, status
	logic [15:0] rows [4][5] = '{
		'{16'h000d, 16'h0014, 16'h0002, 16'h0040, 16'h2000},
		'{16'h0005, 16'h0014, 16'h0001, 16'h0018, 16'h1001},
		'{16'h0001, 16'h0046, 16'h0000, 16'h0046, 16'h0002},
		'{16'h01cd, 16'h003d, 16'h0003, 16'h0041, 16'h3003}};

	queue_tx_control_status queue_tx_control_status_inst (.i_clock(i_clock),
		.i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_in_valid(i_in_valid),
		.o_in_ready(o_in_ready), .i_in_data(i_in_data), .i_in_last(i_in_last),
		.o_tx_valid(o_tx_valid), .i_tx_ready(tx_ready), .o_tx_data(o_tx_data),
		.o_tx_last(o_tx_last), .i_tx_done(done), .i_late_col(late),
		.i_max_col(maxc), .i_full_duplex(i_full_duplex),
		.i_rx_level(i_rx_level), .i_station_addr(48'h0a1b2c3d4e5f),
		.o_backpressure(o_backpressure), .o_tx_running(o_tx_running));
	mac_model mac_model_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_valid(o_tx_valid), .i_last(o_tx_last), .i_stall(stall),
		.i_col(col), .i_data(o_tx_data), .o_ready(tx_ready), .o_done(done),
		.o_late(late), .o_max(maxc), .o_bytes(bytes), .o_first(first));

	initial begin
		forever #12.5 i_clock = !i_clock;
	end

	task chk(input string name, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task wr(input logic [8:0] a, input logic [15:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr

	task rd(input string name, input logic [8:0] a, input logic [15:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		chk(name, e, o_rdata);
		@(posedge i_clock);
	endtask : rd

	// ---------------------------------------------------------------
	// Host stream, ready judged at the negedge before the edge that takes the byte
	// ---------------------------------------------------------------
	task send(input int n);
		for (int k = 0; k < n; k++) begin
			i_in_valid <= 1'b1;
			i_in_data <= 8'(k + 3);
			i_in_last <= (k == n - 1);
			@(negedge i_clock);
			while (o_in_ready !== 1'b1) @(negedge i_clock);
			@(posedge i_clock);
		end
		i_in_valid <= 1'b0;
		i_in_last <= 1'b0;
	endtask : send

	task frame(input string name, input int n, input logic [15:0] e);
		send(n);
		repeat (600) begin
			@(negedge i_clock);
			if (done === 1'b1)
				break;
		end
		chk("done seen", 16'h0001, 16'(done));
		@(posedge i_clock);
		chk(name, e, bytes);
	endtask : frame

	task results;
		$display("Counts: %0d compared, %0d failed", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// Whole run needs under a thousand cycles
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		chk("running", 16'h0000, 16'(o_tx_running));
		rd("ctrl rst", 9'h170, 16'h0000);
		rd("stat rst", 9'h172, 16'h0000);
		wr(9'h170, 16'hffdf);
		rd("ctrl mask", 9'h170, 16'h01dd);
		wr(9'h172, 16'hffff);
		rd("stat ro", 9'h172, 16'h0000);
		rd("unmapped", 9'h174, 16'h0000);
		$display("Test registers done");
		// Padding is only ever enabled with CRC append
		for (int r = 0; r < 4; r++) begin
			col <= rows[r][2][1:0];
			wr(9'h170, rows[r][0]);
			frame("wire bytes", rows[r][1], rows[r][3]);
			chk("first byte", 16'h0003, 16'(first));
			rd("status", 9'h172, rows[r][4]);
		end
		$display("Test frame table done");
		// Enable dropped mid-frame, stalled MAC: frame still completes
		stall <= 1'b1;
		send(20);
		repeat (30) @(posedge i_clock);
		wr(9'h170, 16'h0000);
		stall <= 1'b0;
		frame("stop", 0, 16'h0040);
		chk("stopped", 16'h0000, 16'(o_tx_running));
		rd("stop stat", 9'h172, 16'h3004);
		// Leftover bytes must not survive the flush
		send(5);
		wr(9'h170, 16'h0020);
		@(negedge i_clock);
		chk("flush rdy", 16'h0000, 16'(o_in_ready));
		@(posedge i_clock);
		wr(9'h170, 16'h0001);
		frame("after flush", 20, 16'h0014);
		rd("flush id", 9'h172, 16'h3000);
		$display("Test stop and flush done");
		wr(9'h170, 16'h0010);
		i_rx_level <= 12'h800;
		repeat (3) @(posedge i_clock);
		chk("backpress", 16'h0001, 16'(o_backpressure));
		wr(9'h170, 16'h0000);
		repeat (3) @(posedge i_clock);
		chk("no fc", 16'h0000, 16'(o_backpressure));
		i_full_duplex <= 1'b1;
		i_rx_level <= 12'h000;
		wr(9'h170, 16'h0011);
		i_rx_level <= 12'h800;
		frame("pause", 0, 16'h0040);
		chk("pause da", 16'h0001, 16'(first));
		chk("fd no bp", 16'h0000, 16'(o_backpressure));
		rd("pause stat", 9'h172, 16'h3000);
		$display("Test flow control done");
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		rd("ctrl rst2", 9'h170, 16'h0000);
		rd("stat rst2", 9'h172, 16'h0000);
		$display("Test mid-run reset done");
		results();
	end
endmodule : queue_tx_control_status_test
